// file: logic/cso_ctrl.v
/*
  Clock source and debug clock output controller with Wishbone registers.
  Assumes CLK_SEL is a board strap and the taps come from the clock generator.
*/
// Notes on behaviour
// - Tap select field picks debug clock source.
// - Slew register drives debug pin slew control.
// - Clock-off tri-states pin, enables pull-down.
// - Pin enabled from reset until boot writes.
// - Strap 0 picks USB oscillator, 1 external.
// - Strap 0 forces USB oscillator, regulator on.
// - Strap 1: both off at reset, writable.
// - External clock pull-down register, off after reset.
`include "cso_regs.vh"
module cso_ctrl #(
  parameter N_TAPS = 16
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET_N,
  // Wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [`CSO_ADDR_W-1:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // Clock source
  input wire CLK_SEL,
  input wire [N_TAPS-1:0] CLK_TAPS,
  output reg SYS_SRC_EXT,
  output reg USB_OSC_EN,
  output reg USB_REG_EN,
  output reg EXTERNAL_CLOCK_INPUT_PD_EN,
  // Debug clock output pin
  output reg DBG_CLK_OUT,
  output reg DBG_CLK_OE,
  output reg DBG_CLK_PD_EN,
  output reg [15:0] DBG_CLK_SLEW
);

  // ****************************************
  // Bus decode
  // ****************************************
  wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  // Writes land on the edge at which the master samples ack, not one edge earlier.
  wire wr = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I;
  wire [15:0] idx = WB_ADR_I[`CSO_ADDR_W-1:2];
  wire lo_we = wr & WB_SEL_I[0];
  wire hi_we = wr & WB_SEL_I[1];

  reg [15:0] slew_q;
  reg [15:0] pull_q;
  reg [15:0] clkcfg_q;
  reg [15:0] st3_q;
  reg usb_osc_q;
  reg usb_reg_q;
  reg strap_q;
  reg strap_done_q;

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nv;
    input lo;
    input hi;
    begin
      merge16 = {hi ? nv[15:8] : old[15:8], lo ? nv[7:0] : old[7:0]};
    end
  endfunction

  // ****************************************
  // Strap capture
  // ****************************************
  // The strap is taken once after release; later pin changes are ignored.
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q <= CLK_SEL;
      strap_done_q <= 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      slew_q <= `CSO_RST_SLEW;
      pull_q <= `CSO_RST_PULL;
      clkcfg_q <= `CSO_RST_CLKCFG;
      st3_q <= `CSO_RST_ST3;
    end else if (idx == `CSO_IDX_SLEW) begin
      slew_q <= merge16(slew_q, WB_DAT_I[15:0], lo_we, hi_we);
    end else if (idx == `CSO_IDX_PULL) begin
      pull_q <= merge16(pull_q, WB_DAT_I[15:0], lo_we, hi_we);
    end else if (idx == `CSO_IDX_CLKCFG) begin
      clkcfg_q <= merge16(clkcfg_q, WB_DAT_I[15:0], lo_we, hi_we);
    end else if (idx == `CSO_IDX_STATUS3) begin
      st3_q <= merge16(st3_q, WB_DAT_I[15:0], lo_we, hi_we);
    end
  end

  // USB oscillator and regulator: forced on with strap 0, free with strap 1.
  // Both read off until the strap is known, so strap 1 starts them disabled.
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      usb_osc_q <= 1'b0;
      usb_reg_q <= 1'b0;
    end else if (strap_done_q && !strap_q) begin
      usb_osc_q <= 1'b1;
      usb_reg_q <= 1'b1;
    end else if (!strap_done_q) begin
      usb_osc_q <= ~CLK_SEL;
      usb_reg_q <= ~CLK_SEL;
    end else if (lo_we && idx == `CSO_IDX_USBCTL) begin
      usb_osc_q <= WB_DAT_I[`CSO_USB_OSC_BIT];
      usb_reg_q <= WB_DAT_I[`CSO_USB_REG_BIT];
    end
  end

  // ****************************************
  // Read data and acknowledge
  // ****************************************
  reg [15:0] rd_d;
  always @* begin
    case (idx)
      `CSO_IDX_SLEW: rd_d = slew_q;
      `CSO_IDX_PULL: rd_d = pull_q;
      `CSO_IDX_CLKCFG: rd_d = clkcfg_q;
      `CSO_IDX_STATUS3: rd_d = st3_q;
      `CSO_IDX_USBCTL: rd_d = {13'h0000, strap_q, usb_reg_q, usb_osc_q};
      default: rd_d = 16'h0000;
    endcase
  end

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= req ? {16'h0000, rd_d} : 32'h00000000;
    end
  end

  // ****************************************
  // Pin and clock-source outputs
  // ****************************************
  wire tap_sel;
  wire pin_out_d;
  wire pin_oe_d;
  wire pin_pd_d;

  cso_tap_mux #(
    .N_TAPS(N_TAPS),
    .SEL_W(`CSO_CLKCFG_SRC_W)
  ) u_mux (
    .taps(CLK_TAPS),
    .sel(clkcfg_q[`CSO_CLKCFG_SRC_LSB +: `CSO_CLKCFG_SRC_W]),
    .tap_out(tap_sel)
  );

  cso_pin_ctl u_pin (
    .pin_off(st3_q[`CSO_ST3_CLOCK_PIN_OFF_BIT_BIT]),
    .data_in(tap_sel),
    .pin_out(pin_out_d),
    .pin_oe(pin_oe_d),
    .pin_pd_en(pin_pd_d)
  );

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DBG_CLK_OUT <= 1'b0;
      DBG_CLK_OE <= 1'b1;
      DBG_CLK_PD_EN <= 1'b0;
      DBG_CLK_SLEW <= `CSO_RST_SLEW;
      SYS_SRC_EXT <= 1'b0;
      USB_OSC_EN <= 1'b0;
      USB_REG_EN <= 1'b0;
      EXTERNAL_CLOCK_INPUT_PD_EN <= 1'b0;
    end else begin
      DBG_CLK_OUT <= pin_out_d;
      DBG_CLK_OE <= pin_oe_d;
      DBG_CLK_PD_EN <= pin_pd_d;
      DBG_CLK_SLEW <= slew_q;
      SYS_SRC_EXT <= strap_done_q ? strap_q : CLK_SEL;
      USB_OSC_EN <= usb_osc_q;
      USB_REG_EN <= usb_reg_q;
      // Pull-inhibit bit set means the pull-down is off.
      EXTERNAL_CLOCK_INPUT_PD_EN <= ~pull_q[`CSO_PULL_EXTERNAL_CLOCK_INPUT_BIT];
    end
  end

endmodule // cso_ctrl

// file: logic/cso_regs.vh
/*
  Register map, field positions and reset values of the clock source and
  debug clock output controller.
  Assumes a Wishbone slave with 32-bit data and word-aligned byte addresses.
*/
`ifndef CSO_REGS_VH
`define CSO_REGS_VH

// ****************************************
// Register word indices
// ****************************************
// Printed offsets include an odd one and are not all multiples of four, so they are indices.
`define CSO_IDX_SLEW 16'h1C16
`define CSO_IDX_PULL 16'h1C18
`define CSO_IDX_CLKCFG 16'h1C20
`define CSO_IDX_STATUS3 16'h1C21
`define CSO_IDX_USBCTL 16'h1C22
`define CSO_ADDR_W 18

// ****************************************
// Fields
// ****************************************
`define CSO_CLKCFG_SRC_LSB 0
`define CSO_CLKCFG_SRC_W 4
`define CSO_ST3_CLOCK_PIN_OFF_BIT_BIT 2
`define CSO_PULL_EXTERNAL_CLOCK_INPUT_BIT 0
`define CSO_USB_OSC_BIT 0
`define CSO_USB_REG_BIT 1
`define CSO_USB_SEL_BIT 2

// ****************************************
// Reset values
// ****************************************
`define CSO_RST_SLEW 16'h0000
`define CSO_RST_PULL 16'h0001
`define CSO_RST_CLKCFG 16'h0000
`define CSO_RST_ST3 16'h0000

`endif

// file: logic/cso_pin_ctl.v
/*
  Output driver control for one tri-state pin with automatic pull-down.
  Assumes the enclosing module registers all outputs it passes on.
*/
module cso_pin_ctl (
  // Control
  input wire pin_off,
  input wire data_in,
  // Pad
  output wire pin_out,
  output wire pin_oe,
  output wire pin_pd_en
);

  assign pin_oe = ~pin_off;
  assign pin_out = pin_off ? 1'b0 : data_in;
  assign pin_pd_en = pin_off;

endmodule // cso_pin_ctl

// file: logic/cso_tap_mux.v
/*
  Selects one of several clock-generator taps for the debug clock output.
  Assumes taps are synchronous levels in the REF_CLK domain.
*/
module cso_tap_mux #(
  parameter N_TAPS = 16,
  parameter SEL_W = 4
) (
  // Taps
  input wire [N_TAPS-1:0] taps,
  input wire [SEL_W-1:0] sel,
  // Result
  output wire tap_out
);

  // Out-of-range selections return a quiet low.
  assign tap_out = (sel < N_TAPS) ? taps[sel] : 1'b0;

endmodule // cso_tap_mux

// file: tb/cso_ctrl_monitor.sv
/* Checker for the clock source controller.
   Assumes a bind to cso_ctrl and a strap held still within each reset. */
module cso_ctrl_monitor (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // Source and pin
  input wire logic CLK_SEL,
  input wire logic SYS_SRC_EXT,
  input wire logic USB_OSC_EN,
  input wire logic USB_REG_EN,
  input wire logic EXTERNAL_CLOCK_INPUT_PD_EN,
  input wire logic DBG_CLK_OUT,
  input wire logic DBG_CLK_OE,
  input wire logic DBG_CLK_PD_EN
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  chk_pin_pull: assert property (DBG_CLK_OE != DBG_CLK_PD_EN) else $error("pull overlap");
  chk_off_quiet: assert property (!DBG_CLK_OE |-> !DBG_CLK_OUT) else $error("off pin high");
  chk_boot_drive: assert property ($rose(RESET_N) |-> DBG_CLK_OE [*3]) else $error("pin off");
  chk_strap_apply: assert property ($rose(RESET_N) |-> ##3 (SYS_SRC_EXT == CLK_SEL &&
    USB_OSC_EN != CLK_SEL && USB_REG_EN != CLK_SEL)) else $error("strap not applied");
  chk_usb_locked: assert property (!SYS_SRC_EXT && USB_OSC_EN && USB_REG_EN
    |=> USB_OSC_EN && USB_REG_EN) else $error("usb disabled");
  chk_pull_reset: assert property ($rose(RESET_N) |-> !EXTERNAL_CLOCK_INPUT_PD_EN [*3]) else $error("pull on");
  chk_strap_fixed: assert property ($past(RESET_N, 3) |-> $stable(SYS_SRC_EXT)) else $error("src moved");
  chk_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("long ack");
endmodule // cso_ctrl_monitor

bind cso_ctrl cso_ctrl_monitor mon (.*);

// file: tb/cso_board.sv
/* Board model: strap pin and clock generator taps.
   Assumes the bench changes its inputs just after a rising edge. */
module cso_board (
  // Clock
  input wire logic REF_CLK,
  // Settings
  input wire logic strap_hi,
  input wire logic [15:0] tap_pat,
  // Pins
  output logic CLK_SEL,
  output logic [15:0] CLK_TAPS
);
  timeunit 1ns;
  timeprecision 1ns;
  assign CLK_SEL = strap_hi;
  always_ff @(posedge REF_CLK) CLK_TAPS <= tap_pat;
endmodule // cso_board

// file: tb/cso_testbench.sv
/* Self-checking bench for the clock source controller.
   Assumes the board model and the bound checker. */
`include "cso_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
  logic REF_CLK = 0, RESET_N = 0, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, strap_hi = 0;
  logic [`CSO_ADDR_W-1:0] WB_ADR_I = 0;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 0, WB_DAT_O, rd;
  logic WB_ACK_O, CLK_SEL, SYS_SRC_EXT, USB_OSC_EN, USB_REG_EN, EXTERNAL_CLOCK_INPUT_PD_EN;
  logic DBG_CLK_OUT, DBG_CLK_OE, DBG_CLK_PD_EN;
  logic [15:0] CLK_TAPS, DBG_CLK_SLEW, tap_pat = 0;
  int failures = 0, checks_done = 0, cycles = 0;
  cso_ctrl dut (.*);
  cso_board board (.REF_CLK(REF_CLK), .strap_hi(strap_hi), .tap_pat(tap_pat),
    .CLK_SEL(CLK_SEL), .CLK_TAPS(CLK_TAPS));
  initial forever #5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if (++cycles == 20000) begin
    failures++;
    close_out();
  end
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic boot(input logic s);
    @(posedge REF_CLK);
    RESET_N <= 0;
    strap_hi <= s;
    repeat (4) @(posedge REF_CLK);
    RESET_N <= 1;
    repeat (5) @(negedge REF_CLK);
  endtask
  // Ack and read data are taken at the rising edge; the request is released there too.
  task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n = 0;
    @(posedge REF_CLK);
    WB_CYC_I <= 1;
    WB_STB_I <= 1;
    WB_WE_I <= w;
    WB_SEL_I <= 4'h3;
    WB_ADR_I <= {idx, 2'h0};
    WB_DAT_I <= d;
    do @(posedge REF_CLK); while (WB_ACK_O !== 1'b1 && ++n < 50);
    if (WB_ACK_O !== 1'b1) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, WB_ACK_O, 1'b1);
    end
    rd = WB_DAT_O;
    WB_CYC_I <= 0;
    WB_STB_I <= 0;
    @(posedge REF_CLK);
    @(negedge REF_CLK);
  endtask
  task automatic t_regs;
    `CHK(DBG_CLK_SLEW, 16'h0)
    wb(1, `CSO_IDX_SLEW, 32'hA5C3);
    `CHK(DBG_CLK_SLEW, 16'hA5C3)
    wb(0, `CSO_IDX_SLEW, 32'h0);
    `CHK(rd, 32'hA5C3)
    wb(0, `CSO_IDX_PULL, 32'h0);
    `CHK({rd[0], EXTERNAL_CLOCK_INPUT_PD_EN}, 2'h2)
    wb(1, `CSO_IDX_PULL, 32'h0);
    `CHK(EXTERNAL_CLOCK_INPUT_PD_EN, 1'b1)
    wb(0, 16'h0100, 32'h0);
    `CHK(rd, 32'h0)
    $display("regs test done");
  endtask
  task automatic t_pin;
    `CHK({DBG_CLK_OE, DBG_CLK_PD_EN}, 2'h2)
    wb(1, `CSO_IDX_STATUS3, 32'h4);
    `CHK({DBG_CLK_OE, DBG_CLK_PD_EN, DBG_CLK_OUT}, 3'h2)
    wb(1, `CSO_IDX_STATUS3, 32'h0);
    `CHK({DBG_CLK_OE, DBG_CLK_PD_EN}, 2'h2)
    $display("pin test done");
  endtask
  task automatic t_taps;
    for (int s = 0; s < 16; s++) begin
      @(posedge REF_CLK);
      tap_pat <= 16'h1 << s;
      wb(1, `CSO_IDX_CLKCFG, 32'(s));
      `CHK(DBG_CLK_OUT, 1'b1)
      @(posedge REF_CLK);
      tap_pat <= ~(16'h1 << s);
      repeat (3) @(negedge REF_CLK);
      `CHK(DBG_CLK_OUT, 1'b0)
    end
    $display("taps test done");
  endtask
  task automatic t_usb(input logic s);
    boot(s);
    `CHK({SYS_SRC_EXT, USB_OSC_EN, USB_REG_EN}, {s, ~s, ~s})
    wb(1, `CSO_IDX_USBCTL, s ? 32'h3 : 32'h0);
    @(posedge REF_CLK);
    strap_hi <= ~s;
    repeat (3) @(negedge REF_CLK);
    `CHK({SYS_SRC_EXT, USB_OSC_EN, USB_REG_EN}, {s, 2'h3})
    $display("usb test done");
  endtask
  initial begin
    boot(1'b0);
    t_regs;
    t_pin;
    t_taps;
    t_usb(1'b0);
    t_usb(1'b1);
    close_out;
  end
endmodule // testbench
